// ---- hw/soar_pkg.sv ----
package soar_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register map, byte addresses of 32-bit words
	localparam int unsigned BUS_ADDR_W = 8;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_OFFLINE = 8'h08;
	localparam logic [7:0] REG_TIMES = 8'h0C;
	localparam logic [7:0] REG_EXTTIME = 8'h10;
	localparam logic [7:0] REG_ATTR = 8'h14;
	localparam logic [7:0] REG_STREAM = 8'h18;
	localparam logic [7:0] REG_DATA = 8'h1C;
	localparam logic [3:0] BE_ALL = 4'hF;

	// Register field positions
	localparam int unsigned ST_AUTO = 0;
	localparam int unsigned ST_ABORT = 1;
	localparam int unsigned ST_OFFLINE_LSB = 8;
	localparam int unsigned ST_SELFTEST_LSB = 16;
	localparam int unsigned ST_CHKPT_LSB = 24;
	localparam int unsigned OFF_CODE_LSB = 0;
	localparam int unsigned OFF_SELFTEST_LSB = 8;
	localparam int unsigned OFF_CHKPT_LSB = 16;
	localparam int unsigned TIMES_OFFSEC_LSB = 0;
	localparam int unsigned TIMES_SHORT_LSB = 16;
	localparam int unsigned ATTR_DATA_LSB = 0;
	localparam int unsigned ATTR_IDX_LSB = 16;

	// Sector count codes for the automatic off-line subcommand
	localparam logic [7:0] SC_DISABLE = 8'h00;
	localparam logic [7:0] SC_ENABLE = 8'hF8;

	// Attribute structure layout
	localparam int unsigned ENTRY_BYTES = 12;
	localparam int unsigned ENTRY_COUNT = 30;
	localparam int unsigned ATTR_BYTES = ENTRY_BYTES * ENTRY_COUNT;
	localparam logic [8:0] OFS_REV = 9'h000;
	localparam logic [15:0] REV_VALUE = 16'h0010;
	localparam logic [8:0] OFS_ENTRY = 9'h002;
	localparam logic [8:0] OFS_OFF_STAT = 9'h16A;
	localparam logic [8:0] OFS_SELFTEST = 9'h16B;
	localparam logic [8:0] OFS_OFF_TIME = 9'h16C;
	localparam logic [8:0] OFS_OFF_CAP = 9'h16F;
	localparam logic [8:0] OFS_SMART_CAP = 9'h170;
	localparam logic [8:0] OFS_ERR_CAP = 9'h172;
	localparam logic [8:0] OFS_CHKPT = 9'h173;
	localparam logic [8:0] OFS_SHORT = 9'h174;
	localparam logic [8:0] OFS_EXT = 9'h175;
	localparam logic [8:0] OFS_EXT_WORD = 9'h177;
	localparam logic [8:0] ONE_BYTE = 9'h001;
	localparam logic [7:0] VAL_OFF_CAP = 8'h1B;
	localparam logic [15:0] VAL_SMART_CAP = 16'h0003;
	localparam logic [7:0] VAL_ERR_CAP = 8'h01;
	localparam logic [7:0] EXT_ESCAPE = 8'hFF;
	localparam int unsigned AUTO_BIT = 7;

	// Attribute entry fields
	localparam logic [3:0] ENT_ID = 4'h0;
	localparam logic [3:0] ENT_FLAGS_LO = 4'h1;
	localparam logic [3:0] ENT_FLAGS_HI = 4'h2;
	localparam logic [3:0] ENT_VALUE = 4'h3;
	localparam logic [7:0] FLAGS_LO_MASK = 8'h3F;
	localparam logic [7:0] NORM_MIN = 8'h01;
	localparam logic [7:0] NORM_MAX = 8'hFD;
	localparam logic [3:0] REMAIN_MAX = 4'h9;

	// Streaming read of the 512-byte structure
	localparam int unsigned WORD_PTR_W = 7;
	localparam logic [6:0] LAST_WORD = 7'h7F;

	////////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic read;
		logic write;
		logic [BUS_ADDR_W-1:0] address;
		logic [31:0] writedata;
		logic [3:0] byteenable;
	} soar_avs_req_t;

	typedef struct packed {
		logic [6:0] offCode;
		logic [7:0] selfTest;
		logic [7:0] checkPoint;
		logic [15:0] offSeconds;
		logic [7:0] shortMin;
		logic [15:0] extMin;
	} soar_report_t;

	typedef enum logic [1:0] {
		SOAR_BUS_IDLE = 2'b00,
		SOAR_BUS_ACK = 2'b01
	} soar_bus_state_t;

endpackage : soar_pkg

// ---- hw/soar_report.sv ----
`timescale 1ns/1ps

module soar_report (
	input wire logic clock,
	input wire logic arst_n,
	input wire soar_pkg::soar_avs_req_t avsReq,
	output logic [31:0] avsReadData,
	output logic avsWaitRequest,
	input wire logic saveEvent,
	output logic autoOffline,
	output logic saveStrobe,
	output logic cmdAbort
);

	////////////////////////////////////////////////////////////////////////////
	// Identifier screen for reported attributes
	function automatic logic idSupported(input logic [7:0] id);
		case (id)
			8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C,
			8'h16, 8'hC0, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6, 8'hC7: begin
				idSupported = 1'b1;
			end
			default: begin
				idSupported = 1'b0;
			end
		endcase
	endfunction : idSupported

	// Keep a normalized value inside its legal band
	function automatic logic [7:0] clampNorm(input logic [7:0] v);
		clampNorm = (v < soar_pkg::NORM_MIN) ? soar_pkg::NORM_MIN
			: ((v > soar_pkg::NORM_MAX) ? soar_pkg::NORM_MAX : v);
	endfunction : clampNorm

	////////////////////////////////////////////////////////////////////////////
	// State
	soar_pkg::soar_bus_state_t busState_reg;
	soar_pkg::soar_bus_state_t busState_next;
	soar_pkg::soar_report_t report_reg;
	soar_pkg::soar_report_t report_next;
	logic waitReq_reg;
	logic [31:0] readData_reg;
	logic [31:0] readData_next;
	logic autoEn_reg;
	logic autoEn_next;
	logic abortFlag_reg;
	logic abortFlag_next;
	logic abortPulse_reg;
	logic savePulse_reg;
	logic [6:0] ptr_reg;
	logic [6:0] ptr_next;
	logic [7:0] sum_reg;
	logic [7:0] sum_next;
	logic [7:0] attrMem [soar_pkg::ATTR_BYTES];

	////////////////////////////////////////////////////////////////////////////
	// Bus decode; a request is taken on the edge that sees waitrequest low
	logic reqSeen;
	logic accept;
	logic wrFull;
	logic wrAccept;
	logic rdAccept;
	logic [31:0] wd;
	logic hitCmd;
	logic hitStatus;
	logic hitOffline;
	logic hitTimes;
	logic hitExt;
	logic hitAttr;
	logic hitStream;
	logic hitData;
	assign reqSeen = avsReq.read | avsReq.write;
	assign accept = reqSeen & ~waitReq_reg;
	assign wrFull = avsReq.byteenable == soar_pkg::BE_ALL;
	assign wrAccept = accept & avsReq.write & wrFull;
	assign rdAccept = accept & avsReq.read;
	assign wd = avsReq.writedata;
	assign hitCmd = avsReq.address == soar_pkg::REG_CMD;
	assign hitStatus = avsReq.address == soar_pkg::REG_STATUS;
	assign hitOffline = avsReq.address == soar_pkg::REG_OFFLINE;
	assign hitTimes = avsReq.address == soar_pkg::REG_TIMES;
	assign hitExt = avsReq.address == soar_pkg::REG_EXTTIME;
	assign hitAttr = avsReq.address == soar_pkg::REG_ATTR;
	assign hitStream = avsReq.address == soar_pkg::REG_STREAM;
	assign hitData = avsReq.address == soar_pkg::REG_DATA;

	////////////////////////////////////////////////////////////////////////////
	// Subcommand decode from the sector count
	logic [7:0] secCount;
	logic subCmd;
	logic cmdOff;
	logic cmdOn;
	logic cmdBad;
	assign secCount = wd[7:0];
	assign subCmd = wrAccept & hitCmd;
	assign cmdOff = subCmd & (secCount == soar_pkg::SC_DISABLE);
	assign cmdOn = subCmd & (secCount == soar_pkg::SC_ENABLE);
	assign cmdBad = subCmd & ~cmdOff & ~cmdOn;

	// Collection flag: only the two legal codes move it, status follows at once
	assign autoEn_next = cmdOn ? 1'b1 : (cmdOff ? 1'b0 : autoEn_reg);
	// Sticky abort: a new abort wins over a write-one clear
	assign abortFlag_next = cmdBad
		| (abortFlag_reg & ~(wrAccept & hitStatus & wd[soar_pkg::ST_ABORT]));

	////////////////////////////////////////////////////////////////////////////
	// Firmware-written report fields
	logic [3:0] remainIn;
	logic [3:0] remainFix;
	assign remainIn = wd[soar_pkg::OFF_SELFTEST_LSB +: 4];
	assign remainFix = (remainIn > soar_pkg::REMAIN_MAX) ? soar_pkg::REMAIN_MAX : remainIn;

	always_comb begin
		report_next = report_reg;
		if (wrAccept & hitOffline) begin
			report_next.offCode = wd[soar_pkg::OFF_CODE_LSB +: 7];
			report_next.selfTest = {wd[soar_pkg::OFF_SELFTEST_LSB + 4 +: 4], remainFix};
			report_next.checkPoint = wd[soar_pkg::OFF_CHKPT_LSB +: 8];
		end
		if (wrAccept & hitTimes) begin
			report_next.offSeconds = wd[soar_pkg::TIMES_OFFSEC_LSB +: 16];
			report_next.shortMin = wd[soar_pkg::TIMES_SHORT_LSB +: 8];
		end
		if (wrAccept & hitExt) begin
			report_next.extMin = wd[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Structure byte lanes for the current stream word
	logic [31:0] streamWord;
	logic [7:0] extByte;
	// Extended time byte escapes to the word field when it does not fit
	assign extByte = (report_reg.extMin >= 16'(soar_pkg::EXT_ESCAPE)) ? soar_pkg::EXT_ESCAPE
		: report_reg.extMin[7:0];

	for (genvar lane = 0; lane < 4; lane++) begin : g_lane
		logic [8:0] addr;
		logic [8:0] off;
		logic [8:0] base;
		logic [4:0] ent;
		logic [3:0] fld;
		logic inEntry;
		logic [7:0] idByte;
		logic [7:0] rawByte;
		logic idOk;
		logic [7:0] laneByte;
		assign addr = {ptr_reg, 2'(lane)};
		assign off = addr - soar_pkg::OFS_ENTRY;
		assign inEntry = (addr >= soar_pkg::OFS_ENTRY) && (addr < soar_pkg::OFS_OFF_STAT);
		assign ent = 5'(off / soar_pkg::ENTRY_BYTES);
		assign fld = 4'(off % soar_pkg::ENTRY_BYTES);
		assign base = 9'(ent * soar_pkg::ENTRY_BYTES);
		assign idByte = inEntry ? attrMem[base] : 8'h00;
		assign rawByte = inEntry ? attrMem[off] : 8'h00;
		// Zero or unlisted identifiers read back as an empty entry
		assign idOk = (idByte != 8'h00) && idSupported(idByte);

		// Byte at this address; multi-byte fields are low byte first
		always_comb begin
			laneByte = 8'h00;
			if (inEntry) begin
				if (idOk) begin
					case (fld)
						soar_pkg::ENT_FLAGS_LO: begin
							laneByte = rawByte & soar_pkg::FLAGS_LO_MASK;
						end
						soar_pkg::ENT_FLAGS_HI: begin
							laneByte = 8'h00;
						end
						soar_pkg::ENT_VALUE: begin
							laneByte = clampNorm(rawByte);
						end
						default: begin
							laneByte = rawByte;
						end
					endcase
				end
			end else begin
				case (addr)
					soar_pkg::OFS_REV: begin
						laneByte = soar_pkg::REV_VALUE[7:0];
					end
					soar_pkg::OFS_REV + soar_pkg::ONE_BYTE: begin
						laneByte = soar_pkg::REV_VALUE[15:8];
					end
					soar_pkg::OFS_OFF_STAT: begin
						laneByte = {autoEn_reg, report_reg.offCode};
					end
					soar_pkg::OFS_SELFTEST: begin
						laneByte = report_reg.selfTest;
					end
					soar_pkg::OFS_OFF_TIME: begin
						laneByte = report_reg.offSeconds[7:0];
					end
					soar_pkg::OFS_OFF_TIME + soar_pkg::ONE_BYTE: begin
						laneByte = report_reg.offSeconds[15:8];
					end
					soar_pkg::OFS_OFF_CAP: begin
						laneByte = soar_pkg::VAL_OFF_CAP;
					end
					soar_pkg::OFS_SMART_CAP: begin
						laneByte = soar_pkg::VAL_SMART_CAP[7:0];
					end
					soar_pkg::OFS_SMART_CAP + soar_pkg::ONE_BYTE: begin
						laneByte = soar_pkg::VAL_SMART_CAP[15:8];
					end
					soar_pkg::OFS_ERR_CAP: begin
						laneByte = soar_pkg::VAL_ERR_CAP;
					end
					soar_pkg::OFS_CHKPT: begin
						laneByte = report_reg.checkPoint;
					end
					soar_pkg::OFS_SHORT: begin
						laneByte = report_reg.shortMin;
					end
					soar_pkg::OFS_EXT: begin
						laneByte = extByte;
					end
					soar_pkg::OFS_EXT_WORD: begin
						laneByte = report_reg.extMin[7:0];
					end
					soar_pkg::OFS_EXT_WORD + soar_pkg::ONE_BYTE: begin
						laneByte = report_reg.extMin[15:8];
					end
					default: begin
						laneByte = 8'h00;
					end
				endcase
			end
		end

		assign streamWord[lane*8 +: 8] = laneByte;
	end

	////////////////////////////////////////////////////////////////////////////
	// Running checksum; last byte closes the sum to zero
	logic lastWord;
	logic [7:0] head3;
	logic [7:0] checkByte;
	logic [31:0] dataWord;
	logic dataAck;
	assign lastWord = ptr_reg == soar_pkg::LAST_WORD;
	assign head3 = streamWord[7:0] + streamWord[15:8] + streamWord[23:16];
	assign checkByte = 8'h00 - (sum_reg + head3);
	assign dataWord = lastWord ? {checkByte, streamWord[23:0]} : streamWord;
	assign dataAck = rdAccept & hitData;
	// Stream restarts on request, after the last word, and wraps cleanly
	assign ptr_next = (wrAccept & hitStream) ? 7'h00 : (dataAck ? ptr_reg + 7'h01 : ptr_reg);
	assign sum_next = ((wrAccept & hitStream) | (dataAck & lastWord)) ? 8'h00
		: (dataAck ? sum_reg + head3 + streamWord[31:24] : sum_reg);

	////////////////////////////////////////////////////////////////////////////
	// Read data, prepared while waitrequest is still high
	logic [31:0] statusWord;
	logic [31:0] offlineWord;
	logic [31:0] timesWord;
	assign statusWord = (32'(autoEn_reg) << soar_pkg::ST_AUTO)
		| (32'(abortFlag_reg) << soar_pkg::ST_ABORT)
		| (32'({autoEn_reg, report_reg.offCode}) << soar_pkg::ST_OFFLINE_LSB)
		| (32'(report_reg.selfTest) << soar_pkg::ST_SELFTEST_LSB)
		| (32'(report_reg.checkPoint) << soar_pkg::ST_CHKPT_LSB);
	assign offlineWord = (32'(report_reg.offCode) << soar_pkg::OFF_CODE_LSB)
		| (32'(report_reg.selfTest) << soar_pkg::OFF_SELFTEST_LSB)
		| (32'(report_reg.checkPoint) << soar_pkg::OFF_CHKPT_LSB);
	assign timesWord = (32'(report_reg.offSeconds) << soar_pkg::TIMES_OFFSEC_LSB)
		| (32'(report_reg.shortMin) << soar_pkg::TIMES_SHORT_LSB);
	assign readData_next = ~(reqSeen & waitReq_reg & avsReq.read) ? readData_reg
		: hitStatus ? statusWord
		: hitOffline ? offlineWord
		: hitTimes ? timesWord
		: hitExt ? 32'(report_reg.extMin)
		: hitData ? dataWord
		: 32'h0000_0000;

	// Every request, mapped or not, is answered one cycle later
	assign busState_next = (busState_reg == soar_pkg::SOAR_BUS_IDLE && reqSeen)
		? soar_pkg::SOAR_BUS_ACK : soar_pkg::SOAR_BUS_IDLE;

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			busState_reg <= soar_pkg::SOAR_BUS_IDLE;
			waitReq_reg <= 1'b1;
			readData_reg <= 32'h0000_0000;
		end else begin
			busState_reg <= busState_next;
			waitReq_reg <= busState_next != soar_pkg::SOAR_BUS_ACK;
			readData_reg <= readData_next;
		end
	end

	// Control and report registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			autoEn_reg <= 1'b0;
			abortFlag_reg <= 1'b0;
			abortPulse_reg <= 1'b0;
			report_reg <= '0;
			ptr_reg <= 7'h00;
			sum_reg <= 8'h00;
		end else begin
			autoEn_reg <= autoEn_next;
			abortFlag_reg <= abortFlag_next;
			abortPulse_reg <= cmdBad;
			report_reg <= report_next;
			ptr_reg <= ptr_next;
			sum_reg <= sum_next;
		end
	end

	// Save requests pass regardless of the collection flag
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			savePulse_reg <= 1'b0;
		end else begin
			savePulse_reg <= saveEvent | cmdOn;
		end
	end

	// Attribute store, one byte per write
	logic [8:0] attrIdx;
	logic attrWe;
	assign attrIdx = wd[soar_pkg::ATTR_IDX_LSB +: 9];
	assign attrWe = wrAccept & hitAttr & (32'(attrIdx) < soar_pkg::ATTR_BYTES);

	always_ff @(posedge clock) begin
		if (attrWe) begin
			attrMem[attrIdx] <= wd[soar_pkg::ATTR_DATA_LSB +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign avsReadData = readData_reg;
	assign avsWaitRequest = waitReq_reg;
	assign autoOffline = autoEn_reg;
	assign saveStrobe = savePulse_reg;
	assign cmdAbort = abortPulse_reg;

endmodule : soar_report

// ---- test/soar_report_asserts.sv ----
`timescale 1ns/1ps

module soar_report_asserts (
	input wire logic clock,
	input wire logic arst_n,
	input wire soar_pkg::soar_avs_req_t avsReq,
	input wire logic [31:0] avsReadData,
	input wire logic avsWaitRequest,
	input wire logic saveEvent,
	input wire logic autoOffline,
	input wire logic saveStrobe,
	input wire logic cmdAbort
);
	logic cmdHit;
	logic offHit;
	logic onHit;
	logic badHit;

	////////////////////////////////////////////////////////////////////////////
	// Accepted subcommand writes by count
	assign cmdHit = avsReq.write && !avsWaitRequest && avsReq.address == soar_pkg::REG_CMD
		&& avsReq.byteenable == soar_pkg::BE_ALL;
	assign offHit = cmdHit && avsReq.writedata[7:0] == soar_pkg::SC_DISABLE;
	assign onHit = cmdHit && avsReq.writedata[7:0] == soar_pkg::SC_ENABLE;
	assign badHit = cmdHit && !offHit && !onHit;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!arst_n);

	////////////////////////////////////////////////////////////////////////////
	// Bus handshake steps
	sequence reqSeen;
		(avsReq.read || avsReq.write) && avsWaitRequest;
	endsequence
	sequence answerOnce;
		!avsWaitRequest ##1 avsWaitRequest;
	endsequence

	answer_once_a: assert property (reqSeen |=> answerOnce)
		else $error("waitrequest not low for exactly one cycle");
	idle_wait_a: assert property (!(avsReq.read || avsReq.write) |=> avsWaitRequest)
		else $error("waitrequest low without request");
	data_hold_a: assert property ($changed(avsReadData) |-> $past(avsReq.read && avsWaitRequest))
		else $error("read data changed outside a read");
	cmd_off_a: assert property (offHit |=> !autoOffline && !cmdAbort)
		else $error("disable count did not stop collection");
	cmd_on_a: assert property (onHit |=> autoOffline && saveStrobe && !cmdAbort)
		else $error("enable count did not start collection");
	bad_count_a: assert property (badHit |=> $stable(autoOffline) && cmdAbort)
		else $error("invalid count changed state or missed abort");
	abort_cause_a: assert property (cmdAbort |-> $past(badHit) ##1 !cmdAbort)
		else $error("abort pulse without invalid count");
	auto_cause_a: assert property ($changed(autoOffline) |-> $past(offHit || onHit))
		else $error("collection state changed without subcommand");
	save_event_a: assert property (saveEvent |=> saveStrobe)
		else $error("save request not passed on");
	strobe_cause_a: assert property (saveStrobe |-> $past(saveEvent) || $past(onHit))
		else $error("save strobe without cause");
endmodule : soar_report_asserts

bind soar_report soar_report_asserts chk (
	.clock(clock),
	.arst_n(arst_n),
	.avsReq(avsReq),
	.avsReadData(avsReadData),
	.avsWaitRequest(avsWaitRequest),
	.saveEvent(saveEvent),
	.autoOffline(autoOffline),
	.saveStrobe(saveStrobe),
	.cmdAbort(cmdAbort)
);

// ---- test/soar_host_model.sv ----
`timescale 1ns/1ps

module soar_host_model (
	input wire logic clock,
	output soar_pkg::soar_avs_req_t avsReq,
	input wire logic avsWaitRequest,
	input wire logic [31:0] avsReadData
);
	logic [31:0] burstData [128];

	// Bus idle at time zero
	initial begin
		avsReq = '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// Hold one request until cnt answers are sampled; reads stay up back to back
	task automatic transfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
		input int cnt, output logic ok);
		int got;
		int tries;
		got = 0;
		@(posedge clock);
		avsReq.read <= rd;
		avsReq.write <= !rd;
		avsReq.address <= a;
		avsReq.writedata <= d;
		avsReq.byteenable <= soar_pkg::BE_ALL;
		for (tries = 0; tries < 4 * cnt + 8 && got < cnt; tries++) begin
			@(posedge clock);
			if (avsWaitRequest === 1'b0) begin
				burstData[got] = avsReadData;
				got++;
			end
		end
		ok = (got == cnt);
		// Released address and data lines show the inverse, never the stale value
		avsReq.read <= 1'b0;
		avsReq.write <= 1'b0;
		avsReq.address <= ~a;
		avsReq.writedata <= ~d;
	endtask : transfer

	// Count loaded, then the subcommand issued in one write
	task automatic issue_auto(input logic [7:0] count, output logic ok);
		transfer(1'b0, soar_pkg::REG_CMD, {24'h000000, count}, 1, ok);
	endtask : issue_auto

	// Escape byte sends the host to the word field
	function automatic logic [15:0] ext_minutes(input logic [7:0] b, input logic [15:0] w);
		return (b == 8'hFF) ? w : {8'h00, b};
	endfunction : ext_minutes

	// Structure accepted only when all bytes sum to zero
	function automatic logic sum_ok();
		logic [7:0] s;
		s = 8'h00;
		for (int n = 0; n < 512; n++) begin
			s = s + burstData[n / 4][8 * (n % 4) +: 8];
		end
		return s == 8'h00;
	endfunction : sum_ok
endmodule : soar_host_model

// ---- test/soar_report_tb.sv ----
`timescale 1ns/1ps

`define CHK(g, e, m) begin checkCount++; if ((g) !== (e)) begin nErrors++; \
	$display("mismatch at %0t: %s", $time, m); end end

module soar_report_tb;
	logic clock;
	logic arst_n;
	logic saveEvent;
	soar_pkg::soar_avs_req_t avsReq;
	logic [31:0] avsReadData;
	logic avsWaitRequest;
	logic autoOffline;
	logic saveStrobe;
	logic cmdAbort;
	logic [7:0] expB [512];
	int nErrors = 0;
	int checkCount = 0;

	soar_report dut (.clock(clock), .arst_n(arst_n), .avsReq(avsReq),
		.avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .saveEvent(saveEvent),
		.autoOffline(autoOffline), .saveStrobe(saveStrobe), .cmdAbort(cmdAbort));
	soar_host_model host (.clock(clock), .avsReq(avsReq), .avsWaitRequest(avsWaitRequest),
		.avsReadData(avsReadData));

	// 125 MHz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checkCount, nErrors);
		if (nErrors == 0 && checkCount > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : give_verdict

	// Bus wait ran out
	task automatic hang(input logic ok);
		if (ok !== 1'b1) begin
			nErrors++;
			$display("mismatch at %0t: bus wait ran out", $time);
			give_verdict();
		end
	endtask : hang

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ok;
		host.transfer(1'b0, a, d, 1, ok);
		hang(ok);
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic ok;
		host.transfer(1'b1, a, 32'h00000000, 1, ok);
		hang(ok);
		d = host.burstData[0];
	endtask : rd

	task automatic cmd(input logic [7:0] c);
		logic ok;
		host.issue_auto(c, ok);
		hang(ok);
	endtask : cmd

	////////////////////////////////////////////////////////////////////////////
	// Entry content: ids cover listed, unlisted and zero
	function automatic logic [7:0] id_of(input int k);
		if (k < 12) return 8'(k) + 8'h01;
		if (k == 12) return 8'h16;
		if (k < 21) return 8'hB3 + 8'(k);
		if (k == 21) return 8'h00;
		return 8'hE0 + 8'(k);
	endfunction : id_of

	function automatic logic sup(input logic [7:0] i);
		return (i >= 8'h01 && i <= 8'h0C && i != 8'h06 && i != 8'h0B) || i == 8'h16
			|| (i >= 8'hC0 && i <= 8'hC7 && i != 8'hC3);
	endfunction : sup

	function automatic logic [7:0] raw_byte(input int k, input int b);
		case (b)
			0: return id_of(k);
			1: return {2'b11, 6'(k)};
			2: return 8'hA5;
			3: return (k == 0) ? 8'h00 : (k == 1) ? 8'hFE : 8'h40 + 8'(k);
			default: return 8'h80 + 8'(k + b);
		endcase
	endfunction : raw_byte

	function automatic logic [7:0] exp_byte(input int k, input int b);
		logic [7:0] r;
		r = raw_byte(k, b);
		if (!sup(id_of(k)) || b == 2) return 8'h00;
		if (b == 1) return r & 8'h3F;
		if (b == 3) return (r < 8'h01) ? 8'h01 : (r > 8'hFD) ? 8'hFD : r;
		return r;
	endfunction : exp_byte

	////////////////////////////////////////////////////////////////////////////
	// Enable and disable in turn, state seen on pins and in status
	task automatic t_auto();
		logic [31:0] d;
		`CHK(autoOffline, 1'b0, "state after reset")
		for (int i = 0; i < 4; i++) begin
			cmd(i[0] ? soar_pkg::SC_DISABLE : soar_pkg::SC_ENABLE);
			#1;
			`CHK({autoOffline, saveStrobe, cmdAbort}, {!i[0], !i[0], 1'b0}, "auto")
			rd(soar_pkg::REG_STATUS, d);
			`CHK({d[15], d[0]}, {!i[0], !i[0]}, "status auto bit")
		end
		$display("test auto done");
	endtask : t_auto

	// Invalid counts in both states, sticky flag and unmapped place
	task automatic t_bad();
		logic [31:0] d;
		for (int j = 0; j < 4; j++) begin
			cmd(j[0] ? soar_pkg::SC_ENABLE : soar_pkg::SC_DISABLE);
			cmd((j == 0) ? 8'h01 : (j == 1) ? 8'hF1 : (j == 2) ? 8'hFF : 8'h7F);
			#1;
			`CHK({cmdAbort, autoOffline}, {1'b1, j[0]}, "invalid count")
		end
		rd(soar_pkg::REG_STATUS, d);
		`CHK(d[1], 1'b1, "abort flag")
		wr(soar_pkg::REG_STATUS, 32'h00000002);
		wr(8'h40, 32'h00000001);
		#1;
		`CHK({cmdAbort, autoOffline}, 2'b01, "unmapped write")
		rd(soar_pkg::REG_STATUS, d);
		`CHK(d[1], 1'b0, "abort flag cleared")
		rd(8'h40, d);
		`CHK(d, 32'h00000000, "unmapped read")
		$display("test invalid count done");
	endtask : t_bad

	// Save request passes while collection is off
	task automatic t_save();
		cmd(soar_pkg::SC_DISABLE);
		@(posedge clock);
		saveEvent <= 1'b1;
		@(posedge clock);
		saveEvent <= 1'b0;
		#1;
		`CHK(saveStrobe, 1'b1, "save strobe")
		@(posedge clock);
		#1;
		`CHK(saveStrobe, 1'b0, "save strobe end")
		$display("test save done");
	endtask : t_save

	// Every state code, outcome nibbles 0 to 7 and F, remaining clamped to 9
	task automatic t_status();
		logic [31:0] d;
		logic [3:0] h;
		logic [6:0] c;
		for (int i = 0; i < 9; i++) begin
			h = (i < 8) ? 4'(i) : 4'hF;
			c = (i % 5 == 0) ? 7'h00 : (i % 5 < 3) ? 7'(2 * (i % 5)) : 7'(i % 5 + 2);
			wr(soar_pkg::REG_OFFLINE, {8'h00, 8'hC3, h, 4'hC, 1'b0, c});
			rd(soar_pkg::REG_STATUS, d);
			`CHK(d[15:8], {1'b0, c}, "off-line status")
			`CHK(d[31:16], {8'hC3, h, 4'h9}, "self-test status")
		end
		$display("test status done");
	endtask : t_status

	// Whole structure read back to back and compared byte for byte
	task automatic t_struct(input logic [15:0] ext, input logic on, input logic [6:0] code);
		logic ok;
		logic [7:0] s;
		logic [31:0] w;
		cmd(on ? soar_pkg::SC_ENABLE : soar_pkg::SC_DISABLE);
		wr(soar_pkg::REG_OFFLINE, {8'h00, 8'h5A, 8'hFC, 1'b0, code});
		wr(soar_pkg::REG_TIMES, {8'h00, 8'h0F, 16'h1234});
		wr(soar_pkg::REG_EXTTIME, {16'h0000, ext});
		wr(soar_pkg::REG_STREAM, 32'h00000000);
		host.transfer(1'b1, soar_pkg::REG_DATA, 32'h00000000, 128, ok);
		hang(ok);
		for (int n = 0; n < 512; n++) expB[n] = 8'h00;
		expB[0] = 8'h10;
		for (int k = 0; k < 30; k++) for (int b = 0; b < 12; b++) expB[2 + 12 * k + b] = exp_byte(k, b);
		expB[9'h16A] = {on, code};
		expB[9'h16B] = 8'hF9;
		expB[9'h16C] = 8'h34;
		expB[9'h16D] = 8'h12;
		expB[9'h16F] = 8'h1B;
		expB[9'h170] = 8'h03;
		expB[9'h172] = 8'h01;
		expB[9'h173] = 8'h5A;
		expB[9'h174] = 8'h0F;
		expB[9'h175] = (ext >= 16'h00FF) ? 8'hFF : ext[7:0];
		expB[9'h177] = ext[7:0];
		expB[9'h178] = ext[15:8];
		s = 8'h00;
		for (int n = 0; n < 511; n++) s = s + expB[n];
		expB[511] = 8'h00 - s;
		for (int n = 0; n < 128; n++) begin
			w = {expB[4 * n + 3], expB[4 * n + 2], expB[4 * n + 1], expB[4 * n]};
			if (n > 0 && n < 90) begin
				`CHK(host.burstData[n], w, "entry word")
			end else begin
				`CHK(host.burstData[n], w, "field word")
			end
		end
		`CHK(host.sum_ok(), 1'b1, "checksum")
		w = host.burstData[93];
		`CHK(host.ext_minutes(w[15:8], {host.burstData[94][7:0], w[31:24]}), ext, "ext")
		rd(soar_pkg::REG_OFFLINE, w);
		`CHK(w, {8'h00, 8'h5A, 8'hF9, 1'b0, code}, "off-line register")
		rd(soar_pkg::REG_TIMES, w);
		`CHK(w, {8'h00, 8'h0F, 16'h1234}, "times register")
		rd(soar_pkg::REG_EXTTIME, w);
		`CHK(w, {16'h0000, ext}, "extended time register")
		$display("test structure done");
	endtask : t_struct

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		arst_n = 1'b0;
		saveEvent = 1'b0;
		repeat (2) @(posedge clock);
		arst_n <= 1'b1;
		#1;
		t_auto();
		t_bad();
		t_save();
		t_status();
		for (int k = 0; k < 30; k++) for (int b = 0; b < 12; b++)
			wr(soar_pkg::REG_ATTR, {7'h00, 9'(12 * k + b), 8'h00, raw_byte(k, b)});
		t_struct(16'h0123, 1'b1, 7'h02);
		t_struct(16'h00FF, 1'b0, 7'h05);
		t_struct(16'h00FE, 1'b1, 7'h06);
		give_verdict();
	end
endmodule : soar_report_tb
